//--- core/wwd_defs.svh
// Constants of the windowed watchdog timer: rates, offsets, bit positions and reset values.
`ifndef WWD_DEFS_SVH
`define WWD_DEFS_SVH

// ----------------------------------------------------------------------------
// Clock rates and derived counts
// ----------------------------------------------------------------------------
`define WWD_CORE_CLK_HZ 100000000
`define WWD_LOW_POWER_RC_OSC_HZ 31000
`define WWD_LOW_POWER_RC_OSC_DIV (`WWD_CORE_CLK_HZ / `WWD_LOW_POWER_RC_OSC_HZ)
`define WWD_LOW_POWER_RC_OSC_CNT_W 12
`define WWD_PRE_LAST_5BIT 7'h1F
`define WWD_PRE_LAST_7BIT 7'h7F
`define WWD_PRE_SHIFT_5BIT 5
`define WWD_PRE_SHIFT_7BIT 7
`define WWD_BASE_PERIOD_5BIT_MS 1
`define WWD_BASE_PERIOD_7BIT_MS 4

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define WWD_RSTCTL_OFS 8'h00
`define WWD_CFGRD_OFS 8'h02
`define WWD_POSTCNT_OFS 8'h04
`define WWD_PRECNT_OFS 8'h06

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define WWD_RC_IDLE_BIT 2
`define WWD_RC_SLEEP_BIT 3
`define WWD_RC_TIMEOUT_BIT 4
`define WWD_RC_SWEN_BIT 5
`define WWD_CFG_PS_MSB 3
`define WWD_CFG_PS_LSB 0
`define WWD_CFG_PRESEL_BIT 4
`define WWD_CFG_WINDOW_DISABLE_CFG_BIT 6
`define WWD_CFG_HWEN_BIT 7

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define WWD_CFG_RST 8'hFF
`define WWD_DATA_RST 16'h0000

`endif

//--- core/wwd_pkg.sv
// Types shared by the windowed watchdog timer.
package wwd_pkg;

    typedef logic [7:0] wwd_addr_t;
    typedef logic [15:0] wwd_data_t;
    typedef logic [7:0] wwd_cfg_t;

    typedef enum logic [2:0] {
        WWD_PM_RUN = 3'b001,
        WWD_PM_SLEEP = 3'b010,
        WWD_PM_IDLE = 3'b100
    } wwd_pmode_t;

endpackage : wwd_pkg

//--- core/wwd_watchdog_timer.sv
// Windowed watchdog timer with prescaler, postscaler, power-save handling and reset control bits.
`timescale 1ns/1ps
`default_nettype none
`include "wwd_defs.svh"

// Overview of operation
// - Watchdog ticks come from the low-power RC oscillator, switched on while enabled.
// - Prescaler divides oscillator ticks by 32 or 128, chosen by one config bit.
// - Nominal base period after prescaler is 1 ms or 4 ms.
// - Four-bit postscale field picks one of 16 ratios, 1:1 to 1:32768.
// - Any device reset clears watchdog, prescaler and postscaler counts.
// - Completion of any clock switch clears all counts.
// - Entering sleep or idle by power-save instruction clears all counts.
// - Leaving sleep or idle back to normal execution clears all counts.
// - Clear instruction during normal execution restarts counts, window permitting.
// - An enabled watchdog keeps counting in sleep and idle.
// - Timeout in sleep or idle wakes the device instead of resetting it.
// - Timeout flag is cleared only by nrst or by software, never by the watchdog logic itself.
// - In window mode a clear restarts counts only in the final quarter.
// - In window mode an early clear causes a watchdog reset.
// - Window mode is active when the window-disable config bit is zero.
// - Hardware enable config bit set keeps the watchdog always running.
// - With hardware enable zero, watchdog runs exactly while software enable is set.
// - Every device reset clears the software enable bit.
module wwd_watchdog_timer (
    input wire logic core_clk,
    input wire logic nrst,
    input wire wwd_pkg::wwd_addr_t bus_addr,
    input wire wwd_pkg::wwd_data_t bus_wdata,
    input wire logic bus_we,
    input wire logic bus_re,
    output var wwd_pkg::wwd_data_t bus_rdata,
    input wire wwd_pkg::wwd_cfg_t config_word_one,
    input wire logic watchdog_clear_instr,
    input wire logic power_save_instr,
    input wire logic power_save_idle,
    input wire logic osc_switch_done,
    input wire logic wake_event,
    output var logic low_power_rc_osc_en,
    output var logic watchdog_reset_req,
    output var logic watchdog_wake,
    output var logic power_save_active
);
    import wwd_pkg::*;

    // ------------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------------
    localparam logic [`WWD_LOW_POWER_RC_OSC_CNT_W-1:0] LOW_POWER_RC_OSC_LAST = `WWD_LOW_POWER_RC_OSC_CNT_W'(`WWD_LOW_POWER_RC_OSC_DIV - 1);

    wwd_cfg_t cfg_meta_ff;
    wwd_cfg_t cfg_ff;
    wwd_pmode_t mode_ff;
    wwd_pmode_t nxt_mode;
    logic [`WWD_LOW_POWER_RC_OSC_CNT_W-1:0] low_power_rc_osc_cnt_ff;
    logic [6:0] pre_cnt_ff;
    logic [14:0] post_cnt_ff;
    logic sw_enable_ff;
    logic timeout_flag_ff;
    logic sleep_flag_ff;
    logic idle_flag_ff;
    wwd_data_t rdata_ff;
    logic osc_en_ff;
    logic reset_req_ff;
    logic wake_ff;
    logic ps_active_ff;

    logic [3:0] post_sel;
    logic pre_sel;
    logic window_en;
    logic hw_en;
    logic running;
    logic in_run;
    logic low_power_rc_osc_tick;
    logic [6:0] pre_last;
    logic pre_tc;
    logic [15:0] post_target;
    logic [14:0] post_last;
    logic timeout;
    logic [25:0] elapsed;
    logic [25:0] period;
    logic win_open;
    logic clr_ok;
    logic early_clr;
    logic wd_reset;
    logic wd_wake;
    logic ps_enter;
    logic ps_exit;
    logic count_clear;
    logic rstctl_wr;

    // ------------------------------------------------------------------------
    // Configuration word
    // ------------------------------------------------------------------------
    // The fuse bits arrive from outside this clock domain, so they pass two flops first.
    // Until the synchroniser delivers the pins, the reset value keeps the hardware enable
    // set, so the watchdog errs on the side of running.
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            cfg_meta_ff <= `WWD_CFG_RST;
            cfg_ff <= `WWD_CFG_RST;
        end else begin
            cfg_meta_ff <= config_word_one;
            cfg_ff <= cfg_meta_ff;
        end
    end

    assign post_sel = cfg_ff[`WWD_CFG_PS_MSB:`WWD_CFG_PS_LSB];
    assign pre_sel = cfg_ff[`WWD_CFG_PRESEL_BIT];
    assign window_en = ~cfg_ff[`WWD_CFG_WINDOW_DISABLE_CFG_BIT];
    assign hw_en = cfg_ff[`WWD_CFG_HWEN_BIT];

    // A set hardware enable overrides software entirely.
    assign running = hw_en | sw_enable_ff;
    // Clear and power-save instructions only act while the core executes.
    assign in_run = (mode_ff == WWD_PM_RUN);

    // ------------------------------------------------------------------------
    // Low-power RC oscillator tick
    // ------------------------------------------------------------------------
    // The oscillator is modelled as a free divider of the core clock that only runs while
    // the watchdog is enabled; its phase is not part of the watchdog counts.
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            low_power_rc_osc_cnt_ff <= '0;
        end else if (!running) begin
            low_power_rc_osc_cnt_ff <= '0;
        end else if (low_power_rc_osc_cnt_ff == LOW_POWER_RC_OSC_LAST) begin
            low_power_rc_osc_cnt_ff <= '0;
        end else begin
            low_power_rc_osc_cnt_ff <= low_power_rc_osc_cnt_ff + `WWD_LOW_POWER_RC_OSC_CNT_W'(1);
        end
    end

    assign low_power_rc_osc_tick = running && (low_power_rc_osc_cnt_ff == LOW_POWER_RC_OSC_LAST);

    // ------------------------------------------------------------------------
    // Terminal counts
    // ------------------------------------------------------------------------
    // The base period is 32 or 128 oscillator ticks, nominally 1 ms or 4 ms.
    assign pre_last = pre_sel ? `WWD_PRE_LAST_7BIT : `WWD_PRE_LAST_5BIT;
    assign pre_tc = low_power_rc_osc_tick && (pre_cnt_ff == pre_last);

    // The postscaler holds one less than its ratio, so 1:1 times out on the first
    // prescaler terminal count.
    assign post_target = 16'h0001 << post_sel;
    assign post_last = 15'(post_target - 16'h0001);
    assign timeout = pre_tc && (post_cnt_ff == post_last);

    // ------------------------------------------------------------------------
    // Window check
    // ------------------------------------------------------------------------
    // Elapsed and full period are both in oscillator ticks, so the quarter is exact even
    // at 1:1 postscale where the postscaler alone cannot resolve it.
    always_comb begin
        if (pre_sel) begin
            elapsed = (26'(post_cnt_ff) << `WWD_PRE_SHIFT_7BIT) + 26'(pre_cnt_ff);
            period = 26'(post_target) << `WWD_PRE_SHIFT_7BIT;
        end else begin
            elapsed = (26'(post_cnt_ff) << `WWD_PRE_SHIFT_5BIT) + 26'(pre_cnt_ff);
            period = 26'(post_target) << `WWD_PRE_SHIFT_5BIT;
        end
    end

    assign win_open = (26'(elapsed << 2) >= 26'((period << 1) + period));

    // ------------------------------------------------------------------------
    // Events
    // ------------------------------------------------------------------------
    // A clear is only honoured in run mode; in sleep or idle the core is not executing,
    // so a clear strobe there is treated as noise and leaves the counts alone.
    // An early clear while the watchdog is disabled does nothing at all, since a stopped
    // watchdog has no window to violate.
    assign clr_ok = watchdog_clear_instr && in_run && (!window_en || win_open);
    assign early_clr = running && watchdog_clear_instr && in_run && window_en && !win_open;
    assign wd_reset = (running && timeout && in_run) || early_clr;
    assign wd_wake = running && timeout && !in_run;
    assign ps_enter = power_save_instr && in_run;
    // Leaving power save through a watchdog wake also counts as an exit, so the counts
    // restart from zero rather than carrying the wake tick over.
    assign ps_exit = !in_run && (wake_event || wd_wake);

    // Every restart source clears both counters; a disabled watchdog holds them cleared.
    assign count_clear = wd_reset
        || osc_switch_done
        || ps_enter
        || ps_exit
        || clr_ok
        || !running;

    // ------------------------------------------------------------------------
    // Prescaler and postscaler
    // ------------------------------------------------------------------------
    // A restart always wins over a terminal count in the same cycle.
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            pre_cnt_ff <= '0;
        end else if (count_clear) begin
            pre_cnt_ff <= '0;
        end else if (pre_tc) begin
            pre_cnt_ff <= '0;
        end else if (low_power_rc_osc_tick) begin
            pre_cnt_ff <= pre_cnt_ff + 7'h01;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            post_cnt_ff <= '0;
        end else if (count_clear) begin
            post_cnt_ff <= '0;
        end else if (timeout) begin
            post_cnt_ff <= '0;
        end else if (pre_tc) begin
            post_cnt_ff <= post_cnt_ff + 15'h0001;
        end
    end

    // ------------------------------------------------------------------------
    // Power mode
    // ------------------------------------------------------------------------
    // Entry wins only when no watchdog reset is raised in the same cycle; the reset keeps
    // the core in run mode, and a half-entered sleep would leave the flags inconsistent.
    always_comb begin
        nxt_mode = mode_ff;
        unique case (mode_ff)
            WWD_PM_RUN: begin
                if (ps_enter && !wd_reset) begin
                    nxt_mode = power_save_idle ? WWD_PM_IDLE : WWD_PM_SLEEP;
                end
            end
            WWD_PM_SLEEP, WWD_PM_IDLE: begin
                // Execution resumes after the power-save instruction, not at the reset vector.
                if (ps_exit) begin
                    nxt_mode = WWD_PM_RUN;
                end
            end
            default: begin
                nxt_mode = WWD_PM_RUN;
            end
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            mode_ff <= WWD_PM_RUN;
        end else begin
            mode_ff <= nxt_mode;
        end
    end

    // ------------------------------------------------------------------------
    // Reset control bits
    // ------------------------------------------------------------------------
    // Only the reset control word is writable; every other offset ignores a write.
    assign rstctl_wr = bus_we && (bus_addr == `WWD_RSTCTL_OFS);

    // A watchdog reset is a device reset, so it beats a software write of the enable.
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            sw_enable_ff <= 1'b0;
        end else if (wd_reset) begin
            sw_enable_ff <= 1'b0;
        end else if (rstctl_wr) begin
            sw_enable_ff <= bus_wdata[`WWD_RC_SWEN_BIT];
        end
    end

    // Hardware setting wins over a software clear in the same cycle.
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            timeout_flag_ff <= 1'b0;
        end else if (wd_reset || wd_wake) begin
            timeout_flag_ff <= 1'b1;
        end else if (rstctl_wr) begin
            timeout_flag_ff <= bus_wdata[`WWD_RC_TIMEOUT_BIT];
        end
    end

    // The status bits stay set across a watchdog wake until software clears them.
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            sleep_flag_ff <= 1'b0;
            idle_flag_ff <= 1'b0;
        end else begin
            if (ps_enter && !wd_reset && !power_save_idle) begin
                sleep_flag_ff <= 1'b1;
            end else if (rstctl_wr) begin
                sleep_flag_ff <= bus_wdata[`WWD_RC_SLEEP_BIT];
            end
            if (ps_enter && !wd_reset && power_save_idle) begin
                idle_flag_ff <= 1'b1;
            end else if (rstctl_wr) begin
                idle_flag_ff <= bus_wdata[`WWD_RC_IDLE_BIT];
            end
        end
    end

    // ------------------------------------------------------------------------
    // Register read port
    // ------------------------------------------------------------------------
    // Read data stand only in the cycle after the strobe and are zero otherwise, which
    // makes a stale read easy to spot.
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            rdata_ff <= `WWD_DATA_RST;
        end else if (bus_re) begin
            rdata_ff <= `WWD_DATA_RST;
            unique case (bus_addr)
                `WWD_RSTCTL_OFS: begin
                    rdata_ff[`WWD_RC_SWEN_BIT] <= sw_enable_ff;
                    rdata_ff[`WWD_RC_TIMEOUT_BIT] <= timeout_flag_ff;
                    rdata_ff[`WWD_RC_SLEEP_BIT] <= sleep_flag_ff;
                    rdata_ff[`WWD_RC_IDLE_BIT] <= idle_flag_ff;
                end
                `WWD_CFGRD_OFS: begin
                    rdata_ff <= {8'h00, cfg_ff};
                end
                `WWD_POSTCNT_OFS: begin
                    rdata_ff <= {running, post_cnt_ff};
                end
                `WWD_PRECNT_OFS: begin
                    rdata_ff <= {win_open, 4'h0, mode_ff, 1'b0, pre_cnt_ff};
                end
                default: begin
                    rdata_ff <= `WWD_DATA_RST;
                end
            endcase
        end else begin
            rdata_ff <= `WWD_DATA_RST;
        end
    end

    // ------------------------------------------------------------------------
    // Output flops
    // ------------------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            osc_en_ff <= 1'b0;
        end else begin
            osc_en_ff <= running;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            // Both pulses are registered so that downstream reset and wake logic sees a
            // clean one-cycle strobe with no combinational path from the counters.
            reset_req_ff <= 1'b0;
            wake_ff <= 1'b0;
        end else begin
            reset_req_ff <= wd_reset;
            wake_ff <= wd_wake;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            ps_active_ff <= 1'b0;
        end else begin
            // Taken from the next mode so the status flop lines up with the mode register.
            ps_active_ff <= (nxt_mode != WWD_PM_RUN);
        end
    end

    assign bus_rdata = rdata_ff;
    assign low_power_rc_osc_en = osc_en_ff;
    assign watchdog_reset_req = reset_req_ff;
    assign watchdog_wake = wake_ff;
    assign power_save_active = ps_active_ff;

endmodule : wwd_watchdog_timer
`default_nettype wire

//--- testbench/wwd_watchdog_timer_props.sv
// Port-level assertions for the windowed watchdog timer.
`timescale 1ns/1ps
`default_nettype none
module wwd_watchdog_timer_props (
    input wire logic core_clk,
    input wire logic nrst,
    input wire wwd_pkg::wwd_addr_t bus_addr,
    input wire wwd_pkg::wwd_data_t bus_wdata,
    input wire logic bus_we,
    input wire logic bus_re,
    input wire wwd_pkg::wwd_data_t bus_rdata,
    input wire wwd_pkg::wwd_cfg_t config_word_one,
    input wire logic watchdog_clear_instr,
    input wire logic power_save_instr,
    input wire logic power_save_idle,
    input wire logic osc_switch_done,
    input wire logic wake_event,
    input wire logic low_power_rc_osc_en,
    input wire logic watchdog_reset_req,
    input wire logic watchdog_wake,
    input wire logic power_save_active
);
    import wwd_pkg::*;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!nrst);
    // ------------------------------------------------------------------------
    // Sequences
    // ------------------------------------------------------------------------
    // The pins pass a two-flop synchroniser, so the window setting must have settled first.
    sequence sq_cfg_win;
        (config_word_one[7:6] == 2'b10)[*5];
    endsequence
    sequence sq_early_clear;
        osc_switch_done ##[1:3] (watchdog_clear_instr && !power_save_active && config_word_one[7:6] == 2'b10);
    endsequence
    sequence sq_swen_write;
        bus_we && bus_addr == 8'h00 && bus_wdata[5] && !watchdog_reset_req;
    endsequence
    // ------------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------------
    AST_RESET_QUIET: assert property (disable iff (1'b0) !nrst |=> !watchdog_reset_req && !watchdog_wake &&
        !power_save_active && !low_power_rc_osc_en) else $error("outputs active after a reset edge");
    AST_RESET_PULSE_ONE: assert property (watchdog_reset_req |=> !watchdog_reset_req)
        else $error("reset request longer than one cycle");
    AST_WAKE_PULSE_ONE: assert property (watchdog_wake |=> !watchdog_wake)
        else $error("wake pulse longer than one cycle");
    AST_WAKE_FROM_PS: assert property (watchdog_wake |-> !power_save_active && $past(power_save_active))
        else $error("wake outside power save or mode not left");
    AST_NO_RESET_IN_PS: assert property (watchdog_reset_req |-> !power_save_active)
        else $error("reset request while in power save");
    AST_PS_ENTRY: assert property (power_save_instr && !power_save_active && !watchdog_reset_req |=>
        power_save_active || watchdog_reset_req) else $error("power save not entered");
    AST_PS_EXIT: assert property (power_save_active && wake_event |=> !power_save_active)
        else $error("wake event did not end power save");
    AST_SWEN_OSC: assert property (sq_swen_write |-> ##2 low_power_rc_osc_en)
        else $error("oscillator not enabled by software enable");
    AST_EARLY_CLEAR: assert property (sq_cfg_win ##0 sq_early_clear |=> watchdog_reset_req)
        else $error("early clear in window mode gave no reset");
endmodule : wwd_watchdog_timer_props
`default_nettype wire

//--- testbench/wwd_watchdog_timer_bench.sv
// Self-checking bench for the windowed watchdog timer.
`timescale 1ns/1ps
`default_nettype none
`include "wwd_defs.svh"
module wwd_watchdog_timer_bench;
    import wwd_pkg::*;
    localparam int TICK = `WWD_LOW_POWER_RC_OSC_DIV;
    logic core_clk, nrst, bus_we, bus_re, watchdog_clear_instr, power_save_instr, power_save_idle;
    logic osc_switch_done, wake_event, low_power_rc_osc_en, watchdog_reset_req, watchdog_wake, power_save_active;
    wwd_addr_t bus_addr;
    wwd_data_t bus_wdata, bus_rdata;
    wwd_cfg_t config_word_one;
    int miscompares = 0;
    int total_checks = 0;
    int seed = 16;
    logic rd_pend = 1'b0;
    wwd_data_t rd_q[$], mk_q[$];
    logic [1:0] ev_q[$];
    wwd_watchdog_timer dut_u (.core_clk, .nrst, .bus_addr, .bus_wdata, .bus_we, .bus_re, .bus_rdata,
        .config_word_one, .watchdog_clear_instr, .power_save_instr, .power_save_idle, .osc_switch_done,
        .wake_event, .low_power_rc_osc_en, .watchdog_reset_req, .watchdog_wake, .power_save_active);
    // ------------------------------------------------------------------------
    // Compare and drive tasks
    // ------------------------------------------------------------------------
    task automatic conclude;
        miscompares += ev_q.size() + rd_q.size();
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : conclude
    task automatic cmp_rd(input wwd_data_t got);
        wwd_data_t e = (rd_q.size() > 0) ? rd_q.pop_front() : 16'hFFFF;
        wwd_data_t m = (mk_q.size() > 0) ? mk_q.pop_front() : 16'hFFFF;
        total_checks++;
        if ((got & m) !== e) begin
            miscompares++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got & m, e);
        end
    endtask : cmp_rd
    task automatic cmp_ev(input logic [1:0] got);
        logic [1:0] e = (ev_q.size() > 0) ? ev_q.pop_front() : 2'h0;
        total_checks++;
        if (got !== e) begin
            miscompares++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, e);
        end
    endtask : cmp_ev
    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk);
    endtask : cyc
    task automatic wr(input wwd_addr_t a, input wwd_data_t d);
        @(posedge core_clk);
        bus_we <= 1'b1;
        bus_addr <= a;
        bus_wdata <= d;
        @(posedge core_clk);
        bus_we <= 1'b0;
    endtask : wr
    task automatic rd(input wwd_addr_t a, input wwd_data_t e, input wwd_data_t m);
        @(posedge core_clk);
        bus_re <= 1'b1;
        bus_addr <= a;
        rd_q.push_back(e);
        mk_q.push_back(m);
        @(posedge core_clk);
        bus_re <= 1'b0;
    endtask : rd
    // Event codes: 0 clear, 1 power save, 2 clock switch done, 3 wake source.
    task automatic pulse(input int k, input logic idle);
        @(posedge core_clk);
        {wake_event, osc_switch_done, power_save_instr, watchdog_clear_instr} <= 4'h1 << k;
        power_save_idle <= idle;
        @(posedge core_clk);
        {wake_event, osc_switch_done, power_save_instr, watchdog_clear_instr} <= 4'h0;
    endtask : pulse
    task automatic wait_ev(input int bound);
        int i;
        for (i = 0; i < bound && ev_q.size() > 0; i++) @(posedge core_clk);
        if (ev_q.size() > 0) conclude();
    endtask : wait_ev
    // Outputs are looked at on the falling edge, half a cycle after they are launched.
    always @(negedge core_clk) begin
        if (rd_pend) cmp_rd(bus_rdata);
        if ((watchdog_reset_req | watchdog_wake) !== 1'b0) cmp_ev({watchdog_reset_req, watchdog_wake});
        rd_pend <= bus_re;
    end
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    // ------------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------------
    initial begin
        int evs[3] = '{0, 2, 1};
        {nrst, bus_we, bus_re, watchdog_clear_instr, power_save_instr, power_save_idle} = 6'h00;
        {osc_switch_done, wake_event, bus_addr, bus_wdata} = 26'h0;
        config_word_one = 8'h40;
        cyc(3);
        nrst <= 1'b1;
        rd(8'h00, 16'h0000, 16'hFFFF);
        rd(8'h02, 16'h0040, 16'hFFFF);
        wr(8'h08, 16'($random(seed)));
        rd(8'h08, 16'h0000, 16'hFFFF);
        rd(8'h04, 16'h0000, 16'h8000);
        wr(8'h00, 16'h0020);
        rd(8'h04, 16'h8000, 16'h8000);
        foreach (evs[i]) begin
            cyc(3 * TICK + 10);
            rd(8'h06, 16'h0102, 16'h077E);
            pulse(evs[i], 1'b0);
            rd(8'h06, (evs[i] == 1) ? 16'h0200 : 16'h0100, 16'h077E);
        end
        rd(8'h00, 16'h0028, 16'h003C);
        cyc(31 * TICK - 20);
        ev_q.push_back(2'b01);
        wait_ev(TICK + 60);
        rd(8'h00, 16'h0038, 16'h003C);
        rd(8'h06, 16'h0100, 16'h077E);
        pulse(1, 1'b1);
        rd(8'h06, 16'h0400, 16'h077E);
        pulse(3, 1'b0);
        rd(8'h06, 16'h0100, 16'h077E);
        rd(8'h00, 16'h0010, 16'h0010);
        wr(8'h00, 16'h0020);
        rd(8'h00, 16'h0020, 16'h003C);
        config_word_one <= 8'h80;
        cyc(6);
        rd(8'h02, 16'h0080, 16'hFFFF);
        pulse(2, 1'b0);
        ev_q.push_back(2'b10);
        pulse(0, 1'b0);
        wait_ev(10);
        rd(8'h00, 16'h0010, 16'h0030);
        rd(8'h04, 16'h8000, 16'h8000);
        cyc(3 * TICK);
        nrst <= 1'b0;
        cyc(3);
        nrst <= 1'b1;
        rd(8'h06, 16'h0100, 16'h077E);
        rd(8'h00, 16'h0000, 16'h0020);
        cyc(3);
        conclude();
    end
endmodule : wwd_watchdog_timer_bench
bind wwd_watchdog_timer wwd_watchdog_timer_props props_u (.core_clk, .nrst, .bus_addr, .bus_wdata, .bus_we,
    .bus_re, .bus_rdata, .config_word_one, .watchdog_clear_instr, .power_save_instr, .power_save_idle,
    .osc_switch_done, .wake_event, .low_power_rc_osc_en, .watchdog_reset_req, .watchdog_wake, .power_save_active);
`default_nettype wire
